/* hdl/srpie_pkg.sv */
// Package of constants and types for the reset, power and extended interrupt-enable block.
package srpie_pkg;

	localparam logic [7:0] SRPIE_PWR_OFFSET   = 8'h87;
	localparam logic [7:0] SRPIE_XIE_OFFSET   = 8'hE6;
	localparam logic [7:0] SRPIE_XIE_RESET    = 8'h00;
	localparam logic [7:0] SRPIE_PWR_RESET    = 8'h00;
	localparam logic [7:0] SRPIE_CTL_OFFSET   = 8'hF8;
	localparam logic [7:0] SRPIE_CTL_RESET    = 8'h00;
	localparam logic [7:0] SRPIE_PORT_RESET   = 8'hFF;
	localparam logic [15:0] SRPIE_PC_RESET    = 16'h0000;

	localparam int SRPIE_XIE_CMP_BIT   = 5;
	localparam int SRPIE_XIE_CDONE_BIT = 4;
	localparam int SRPIE_XIE_CNT_BIT   = 3;
	localparam int SRPIE_XIE_CWIN_BIT  = 2;
	localparam int SRPIE_XIE_PMAT_BIT  = 1;
	localparam int SRPIE_XIE_TWI_BIT   = 0;
	localparam int SRPIE_XIE_LO        = 0;
	localparam int SRPIE_XIE_HI        = 5;
	localparam int SRPIE_PWR_GF_LO     = 2;
	localparam int SRPIE_PWR_GF_HI     = 7;
	localparam int SRPIE_PWR_STOP_BIT  = 1;
	localparam int SRPIE_PWR_IDLE_BIT  = 0;
	localparam int SRPIE_CTL_GIE_BIT   = 7;

	localparam logic [3:0] SRPIE_WDT_DIV     = 4'd12;
	localparam logic [3:0] SRPIE_WDT_DIV_MAX = 4'd11;

	localparam int SRPIE_NSRC = 6;

	typedef struct packed {
		logic comparator_rise_flag;
		logic comparator_fall_flag;
		logic conv_done_flag;
		logic counter_array_flag;
		logic conv_window_flag;
		logic port_match_flag;
		logic two_wire_flag;
	} srpie_flags_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} srpie_bus_t;

	typedef struct packed {
		logic       rst_pin_o;
		logic       rst_pin_oe;
		logic [7:0] port_latch;
		logic       port_open_drain;
		logic       weak_pullup_en;
	} srpie_pins_t;

	typedef enum logic [1:0] {
		SRPIE_RUN,
		SRPIE_IDLE,
		SRPIE_STOP
	} srpie_mode_t;

endpackage : srpie_pkg

/* hdl/srpie_top.sv */
// Extended interrupt enable, power mode control and reset state logic.
//Behaviour
//RULE1: Bit 5 gates both comparator flags.
//RULE2: Bit 4 gates conversion-complete flag.
//RULE3: Bit 3 gates all counter array requests.
//RULE4: Bit 2 gates converter window flag.
//RULE5: Bit 1 gates port match requests.
//RULE6: Bit 0 gates two-wire serial requests.
//RULE7: Power bits 7:2 are plain flags.
//RULE8: Power bit 1 write enters stop.
//RULE9: Power bit 0 write halts CPU clock.
//RULE10: Stop and idle bits read zero.
//RULE11: Reset halts, resets registers, ports, interrupts.
//RULE12: Reset keeps data memory, resets stack.
//RULE13: Port latches ones, open-drain, pull-ups on.
//RULE14: Supply/power-on reset drives reset pin low.
//RULE15: Reset exit clears PC, internal oscillator.
//RULE16: Watchdog enabled, clock divided by 12.
//RULE17: First fetch from address zero.
//RULE18: Global enable gates every source.
//RULE19: Masked flags still set, raise nothing.
//RULE20: Request or reset ends idle mode.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module srpie_top
	import srpie_pkg::*;
(
	// Clock, enable and reset.
	input  wire logic                core_clk,
	input  wire logic                clk_en,
	input  wire logic                sys_rst,
	input  wire logic                por_or_supply_rst,
	// Register port.
	input  wire srpie_pkg::srpie_bus_t bus_in,
	output logic [7:0]               rd_data,
	// Pending flags from peripherals.
	input  wire srpie_pkg::srpie_flags_t flags_in,
	// Requests and core controls.
	output logic [SRPIE_NSRC-1:0]    irq_req,
	output logic                     irq_any,
	output logic                     cpu_clk_en,
	output logic                     osc_run,
	output logic                     cpu_run,
	output logic                     stack_ptr_reset,
	output logic                     timers_en,
	output logic [15:0]              pc_start,
	output logic                     clk_sel_internal,
	output logic                     wdt_en,
	output logic                     wdt_tick,
	output logic                     cpu_mode_idle,
	output logic                     cpu_mode_stop,
	// Pins.
	output var srpie_pkg::srpie_pins_t pins
);
	import srpie_pkg::*;

	logic [7:0]              xie_reg;
	logic [7:0]              pwr_reg;
	logic [7:0]              ctl_reg;
	srpie_mode_t             mode_reg;
	logic [3:0]              wdt_div_reg;
	logic [SRPIE_NSRC-1:0]   src_pend;
	logic [SRPIE_NSRC-1:0]   irq_next;
	logic                    gie;
	logic                    wr_xie;
	logic                    wr_pwr;
	logic                    wr_ctl;

	assign wr_xie = bus_in.wr && (bus_in.addr == SRPIE_XIE_OFFSET);
	assign wr_pwr = bus_in.wr && (bus_in.addr == SRPIE_PWR_OFFSET);
	assign wr_ctl = bus_in.wr && (bus_in.addr == SRPIE_CTL_OFFSET);
	assign gie    = ctl_reg[SRPIE_CTL_GIE_BIT];

	// Extended enable register; the two reserved bits always hold zero.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			xie_reg <= SRPIE_XIE_RESET; // [RULE11]
		end else if (clk_en && wr_xie) begin
			xie_reg <= {2'b00, bus_in.wdata[SRPIE_XIE_HI:SRPIE_XIE_LO]};
		end
	end

	// Power register keeps only the general flags; mode bits are strobes.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_reg <= SRPIE_PWR_RESET; // [RULE11]
		end else if (clk_en && wr_pwr) begin
			pwr_reg <= {bus_in.wdata[SRPIE_PWR_GF_HI:SRPIE_PWR_GF_LO], 2'b00}; // [RULE7] [RULE10]
		end
	end

	// Control register holding the global interrupt enable.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_reg <= SRPIE_CTL_RESET; // [RULE11]
		end else if (clk_en && wr_ctl) begin
			ctl_reg <= {bus_in.wdata[SRPIE_CTL_GIE_BIT], 7'h00};
		end
	end

	// Sources folded to one pending line each; flags are never altered here.
	always_comb begin
		src_pend[SRPIE_XIE_CMP_BIT]   = flags_in.comparator_rise_flag
		                              | flags_in.comparator_fall_flag;
		src_pend[SRPIE_XIE_CDONE_BIT] = flags_in.conv_done_flag;
		src_pend[SRPIE_XIE_CNT_BIT]   = flags_in.counter_array_flag;
		src_pend[SRPIE_XIE_CWIN_BIT]  = flags_in.conv_window_flag;
		src_pend[SRPIE_XIE_PMAT_BIT]  = flags_in.port_match_flag;
		src_pend[SRPIE_XIE_TWI_BIT]   = flags_in.two_wire_flag; // [RULE19]
	end

	// Each source passes only under its own enable and the global enable.
	genvar gi;
	generate
		for (gi = 0; gi < SRPIE_NSRC; gi++) begin : g_mask
			assign irq_next[gi] = src_pend[gi] & xie_reg[gi] & gie; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE18]
		end
	endgenerate

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_req <= '0; // [RULE11]
		end else if (clk_en) begin
			irq_req <= irq_next;
		end
	end

	assign irq_any = |irq_req;

	// Power mode state: idle leaves on a request, stop only on reset.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_reg <= SRPIE_RUN; // [RULE20]
		end else if (clk_en) begin
			unique case (mode_reg)
				SRPIE_RUN: begin
					if (wr_pwr && bus_in.wdata[SRPIE_PWR_STOP_BIT]) begin
						mode_reg <= SRPIE_STOP; // [RULE8]
					end else if (wr_pwr && bus_in.wdata[SRPIE_PWR_IDLE_BIT]) begin
						mode_reg <= SRPIE_IDLE; // [RULE9]
					end
				end
				SRPIE_IDLE: begin
					if (|irq_next) begin
						mode_reg <= SRPIE_RUN; // [RULE20]
					end
				end
				SRPIE_STOP: begin
					mode_reg <= SRPIE_STOP;
				end
				default: begin
					mode_reg <= SRPIE_RUN;
				end
			endcase
		end
	end

	assign cpu_mode_idle = (mode_reg == SRPIE_IDLE);
	assign cpu_mode_stop = (mode_reg == SRPIE_STOP);
	assign cpu_clk_en    = !sys_rst && (mode_reg == SRPIE_RUN); // [RULE9]
	assign osc_run       = (mode_reg != SRPIE_STOP); // [RULE8]

	// Watchdog prescaler runs from reset exit at one twelfth of the clock.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wdt_div_reg <= 4'h0;
			wdt_tick    <= 1'b0;
		end else if (clk_en && osc_run) begin
			wdt_tick <= (wdt_div_reg == SRPIE_WDT_DIV_MAX); // [RULE16]
			if (wdt_div_reg == SRPIE_WDT_DIV_MAX) begin
				wdt_div_reg <= 4'h0;
			end else begin
				wdt_div_reg <= wdt_div_reg + 4'h1;
			end
		end else if (clk_en) begin
			wdt_tick <= 1'b0;
		end
	end

	// Reset state outputs; data memory has no reset path here.
	assign cpu_run          = !sys_rst; // [RULE11]
	assign timers_en        = !sys_rst; // [RULE11]
	assign stack_ptr_reset  = sys_rst; // [RULE12]
	assign pc_start         = SRPIE_PC_RESET; // [RULE15] [RULE17]
	assign clk_sel_internal = 1'b1; // [RULE15]
	assign wdt_en           = !sys_rst; // [RULE16]

	always_comb begin
		pins.port_latch      = SRPIE_PORT_RESET; // [RULE13]
		pins.port_open_drain = sys_rst; // [RULE13]
		pins.weak_pullup_en  = 1'b1; // [RULE13]
		pins.rst_pin_o       = 1'b0;
		pins.rst_pin_oe      = sys_rst && por_or_supply_rst; // [RULE14]
	end

	// Read data one cycle after the strobe; mode bits read back as zero.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= 8'h00;
		end else if (clk_en) begin
			if (bus_in.rd) begin
				unique case (bus_in.addr)
					SRPIE_XIE_OFFSET: rd_data <= xie_reg;
					SRPIE_PWR_OFFSET: rd_data <= pwr_reg; // [RULE10]
					SRPIE_CTL_OFFSET: rd_data <= ctl_reg;
					default:          rd_data <= 8'h00;
				endcase
			end else begin
				rd_data <= 8'h00;
			end
		end
	end

	// Checks.
	sequence s_idle_write;
		wr_pwr && bus_in.wdata[SRPIE_PWR_IDLE_BIT] && !bus_in.wdata[SRPIE_PWR_STOP_BIT]
			&& (mode_reg == SRPIE_RUN) && clk_en;
	endsequence

	AST_CMP_MASK: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
		clk_en |=> irq_req[SRPIE_XIE_CMP_BIT] == $past(irq_next[SRPIE_XIE_CMP_BIT]))
		else $error("Comparator request mismatch.");
	AST_CDONE: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE2]
		!xie_reg[SRPIE_XIE_CDONE_BIT] && clk_en |=> !irq_req[SRPIE_XIE_CDONE_BIT])
		else $error("Masked conversion request passed.");
	AST_CNT: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE3]
		(flags_in.counter_array_flag && xie_reg[SRPIE_XIE_CNT_BIT] && gie && clk_en)
		|=> irq_req[SRPIE_XIE_CNT_BIT])
		else $error("Counter array request lost.");
	AST_GLOBAL: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE18]
		!gie && clk_en |=> irq_req == '0)
		else $error("Request passed with global enable off.");
	AST_PWR_READ: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE10]
		bus_in.rd && bus_in.addr == SRPIE_PWR_OFFSET && clk_en |=> rd_data[1:0] == 2'b00)
		else $error("Mode bits read nonzero.");
	AST_IDLE_ENTER: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE9]
		s_idle_write |=> !cpu_clk_en && osc_run)
		else $error("Idle entry wrong.");
	AST_STOP_ENTER: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE8]
		wr_pwr && bus_in.wdata[SRPIE_PWR_STOP_BIT] && mode_reg == SRPIE_RUN && clk_en
		|=> !osc_run)
		else $error("Stop entry wrong.");
	AST_IDLE_WAKE: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE20]
		cpu_mode_idle && (|irq_next) && clk_en |=> cpu_clk_en)
		else $error("Idle not left on request.");
	AST_WDT_DIV: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE16]
		wdt_tick && clk_en && osc_run |=> !wdt_tick)
		else $error("Watchdog tick too long.");
	AST_RST_PIN: assert property (@(posedge core_clk) // [RULE14]
		sys_rst && por_or_supply_rst |-> pins.rst_pin_oe && !pins.rst_pin_o)
		else $error("Reset pin not driven low.");

	// Each source must both pass when enabled and be blocked when masked.
	AST_CMP_PASS: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
		(flags_in.comparator_fall_flag && xie_reg[SRPIE_XIE_CMP_BIT] && gie && clk_en)
		|=> irq_req[SRPIE_XIE_CMP_BIT])
		else $error("Comparator fall request lost.");

	AST_CMP_BLOCK: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
		!xie_reg[SRPIE_XIE_CMP_BIT] && clk_en |=> !irq_req[SRPIE_XIE_CMP_BIT])
		else $error("Masked comparator request passed.");

	AST_CDONE_PASS: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE2]
		(flags_in.conv_done_flag && xie_reg[SRPIE_XIE_CDONE_BIT] && gie && clk_en)
		|=> irq_req[SRPIE_XIE_CDONE_BIT])
		else $error("Conversion request lost.");

	AST_CNT_BLOCK: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE3]
		!xie_reg[SRPIE_XIE_CNT_BIT] && clk_en |=> !irq_req[SRPIE_XIE_CNT_BIT])
		else $error("Masked counter array request passed.");

	AST_CWIN_PASS: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE4]
		(flags_in.conv_window_flag && xie_reg[SRPIE_XIE_CWIN_BIT] && gie && clk_en)
		|=> irq_req[SRPIE_XIE_CWIN_BIT])
		else $error("Window request lost.");

	AST_CWIN_BLOCK: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE4]
		!xie_reg[SRPIE_XIE_CWIN_BIT] && clk_en |=> !irq_req[SRPIE_XIE_CWIN_BIT])
		else $error("Masked window request passed.");

	AST_PMAT_PASS: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE5]
		(flags_in.port_match_flag && xie_reg[SRPIE_XIE_PMAT_BIT] && gie && clk_en)
		|=> irq_req[SRPIE_XIE_PMAT_BIT])
		else $error("Port match request lost.");

	AST_PMAT_BLOCK: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE5]
		!xie_reg[SRPIE_XIE_PMAT_BIT] && clk_en |=> !irq_req[SRPIE_XIE_PMAT_BIT])
		else $error("Masked port match request passed.");

	AST_TWI_PASS: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
		(flags_in.two_wire_flag && xie_reg[SRPIE_XIE_TWI_BIT] && gie && clk_en)
		|=> irq_req[SRPIE_XIE_TWI_BIT])
		else $error("Two-wire request lost.");

	AST_TWI_BLOCK: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
		!xie_reg[SRPIE_XIE_TWI_BIT] && clk_en |=> !irq_req[SRPIE_XIE_TWI_BIT])
		else $error("Masked two-wire request passed.");

	// Power register storage and read-back.
	AST_PWR_MODE_BITS: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE10]
		pwr_reg[SRPIE_PWR_STOP_BIT:SRPIE_PWR_IDLE_BIT] == 2'b00)
		else $error("Mode bits stored.");

	AST_GF_STORE: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE7]
		wr_pwr && clk_en |=> pwr_reg[SRPIE_PWR_GF_HI:SRPIE_PWR_GF_LO]
			== $past(bus_in.wdata[SRPIE_PWR_GF_HI:SRPIE_PWR_GF_LO]))
		else $error("General flags not stored.");

	AST_GF_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE7]
		!wr_pwr && clk_en |=> $stable(pwr_reg))
		else $error("General flags changed without a write.");

	AST_PWR_READ_GF: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE7]
		bus_in.rd && bus_in.addr == SRPIE_PWR_OFFSET && clk_en |=> rd_data == $past(pwr_reg))
		else $error("General flags read wrong.");

	// Low power modes.
	AST_STOP_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE8]
		cpu_mode_stop |=> cpu_mode_stop)
		else $error("Stop left without reset.");

	AST_STOP_OSC: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE8]
		cpu_mode_stop |-> !osc_run && !cpu_clk_en)
		else $error("Clock running in stop.");

	AST_STOP_WINS: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE8]
		wr_pwr && bus_in.wdata[SRPIE_PWR_STOP_BIT] && bus_in.wdata[SRPIE_PWR_IDLE_BIT]
			&& mode_reg == SRPIE_RUN && clk_en |=> cpu_mode_stop)
		else $error("Stop did not win over idle.");

	AST_IDLE_CLK: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE9]
		cpu_mode_idle |-> !cpu_clk_en && osc_run && timers_en)
		else $error("Idle clocks wrong.");

	AST_IDLE_STAY: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE20]
		cpu_mode_idle && !(|irq_next) && clk_en |=> cpu_mode_idle)
		else $error("Idle left without request.");

	// Reset state, checked while reset is held; pull-ups and reset pin release also checked after reset.
	AST_RST_STATE: assert property (@(posedge core_clk) // [RULE11] [RULE12]
		sys_rst |-> !cpu_run && !timers_en && !cpu_clk_en && stack_ptr_reset && irq_req == '0)
		else $error("Reset state wrong.");

	AST_RST_REGS: assert property (@(posedge core_clk) // [RULE11]
		sys_rst |-> xie_reg == SRPIE_XIE_RESET && pwr_reg == SRPIE_PWR_RESET
			&& ctl_reg == SRPIE_CTL_RESET)
		else $error("Registers not at reset value.");

	AST_PORTS: assert property (@(posedge core_clk) // [RULE13]
		sys_rst |-> pins.port_latch == SRPIE_PORT_RESET && pins.port_open_drain
			&& pins.weak_pullup_en)
		else $error("Port reset state wrong.");

	AST_PULLUP: assert property (@(posedge core_clk) // [RULE13]
		!sys_rst |-> pins.weak_pullup_en)
		else $error("Pull-ups off after reset.");

	AST_RST_PIN_OFF: assert property (@(posedge core_clk) // [RULE14]
		!sys_rst |-> !pins.rst_pin_oe)
		else $error("Reset pin driven outside reset.");

	// Reset exit state.
	AST_EXIT: assert property (@(posedge core_clk) // [RULE15] [RULE17]
		!sys_rst |-> pc_start == SRPIE_PC_RESET && clk_sel_internal)
		else $error("Reset exit state wrong.");

	AST_WDT_EN: assert property (@(posedge core_clk) // [RULE16]
		!sys_rst |-> wdt_en)
		else $error("Watchdog not enabled.");

	// A watchdog tick followed by eleven running cycles gives the next tick.
	sequence s_wdt_tick;
		wdt_tick && clk_en && osc_run;
	endsequence

	sequence s_wdt_gap;
		(clk_en && osc_run) [*8] ##1 (clk_en && osc_run) [*3];
	endsequence

	AST_WDT_PERIOD: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE16]
		s_wdt_tick ##1 s_wdt_gap |=> wdt_tick)
		else $error("Watchdog period wrong.");

endmodule : srpie_top
`default_nettype wire

/* tb/srpie_top_bench.sv */
// Self-checking bench for the reset, power mode and extended interrupt-enable block.
`timescale 1ns/1ps
`default_nettype none
module srpie_top_bench;
	import srpie_pkg::*;
	logic                  core_clk          = 1'b0;
	logic                  clk_en            = 1'b1;
	logic                  sys_rst           = 1'b1;
	logic                  por_or_supply_rst = 1'b1;
	srpie_bus_t            bus               = '0;
	srpie_flags_t          flags             = '0;
	logic [7:0]            rd_data;
	logic [SRPIE_NSRC-1:0] irq_req;
	logic                  irq_any, cpu_clk_en, osc_run, cpu_run, stack_ptr_reset, timers_en;
	logic [15:0]           pc_start;
	logic                  clk_sel_internal, wdt_en, wdt_tick, cpu_mode_idle, cpu_mode_stop;
	srpie_pins_t           pins;
	int                    miscompares = 0;
	int                    tests_run   = 0;
	int                    ticks;

	always #10 core_clk = ~core_clk;

	srpie_top i_srpie_top (.core_clk(core_clk), .clk_en(clk_en), .sys_rst(sys_rst),
		.por_or_supply_rst(por_or_supply_rst), .bus_in(bus), .rd_data(rd_data),
		.flags_in(flags), .irq_req(irq_req), .irq_any(irq_any), .cpu_clk_en(cpu_clk_en),
		.osc_run(osc_run), .cpu_run(cpu_run), .stack_ptr_reset(stack_ptr_reset),
		.timers_en(timers_en), .pc_start(pc_start), .clk_sel_internal(clk_sel_internal),
		.wdt_en(wdt_en), .wdt_tick(wdt_tick), .cpu_mode_idle(cpu_mode_idle),
		.cpu_mode_stop(cpu_mode_stop), .pins(pins));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge core_clk);
		bus.wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input string what, input logic [7:0] exp);
		@(posedge core_clk);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge core_clk);
		bus.rd   <= 1'b0;
		#1 chk(what, exp, rd_data);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : settle

	task automatic rst(input logic por);
		@(posedge core_clk);
		sys_rst           <= 1'b1;
		por_or_supply_rst <= por;
		settle(5);
		chk("cpu run in reset", 0, {cpu_run, cpu_clk_en, timers_en});
		chk("irq in reset", 0, irq_req);
		chk("stack reset", 1, stack_ptr_reset);
		chk("port latch", SRPIE_PORT_RESET, pins.port_latch);
		chk("open drain, pullup", 3, {pins.port_open_drain, pins.weak_pullup_en});
		chk("reset pin drive", {por, 1'b0}, {pins.rst_pin_oe, pins.rst_pin_o});
		@(posedge core_clk);
		sys_rst <= 1'b0;
		settle(1);
		chk("reset pin released", 0, pins.rst_pin_oe);
		chk("pullup after reset", 1, pins.weak_pullup_en);
		chk("pc start", SRPIE_PC_RESET, pc_start);
		chk("internal clock", 1, clk_sel_internal);
		chk("run after reset", 15, {cpu_run, wdt_en, osc_run, cpu_clk_en});
		chk("timers and stack after reset", 2, {timers_en, stack_ptr_reset});
	endtask : rst

	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (3000) @(posedge core_clk);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		rst(1'b1);
		rd(SRPIE_XIE_OFFSET, "xie reset", SRPIE_XIE_RESET);
		rd(SRPIE_PWR_OFFSET, "pwr reset", 8'h00);
		wr(SRPIE_XIE_OFFSET, 8'hFF);
		rd(SRPIE_XIE_OFFSET, "xie stored bits", 8'h3F);
		rd(8'hAA, "unmapped read", 8'h00);
		wr(SRPIE_PWR_OFFSET, 8'hFC);
		rd(SRPIE_PWR_OFFSET, "general flags", 8'hFC);
		chk("flags touch no mode", 3, {osc_run, cpu_clk_en});
		// A write while the enable is low must be lost.
		@(posedge core_clk);
		clk_en <= 1'b0;
		wr(SRPIE_XIE_OFFSET, 8'h00);
		clk_en <= 1'b1;
		rd(SRPIE_XIE_OFFSET, "frozen write", 8'h3F);
		@(posedge core_clk);
		flags <= '1;
		settle(2);
		chk("irq global off", 0, irq_req);
		wr(SRPIE_CTL_OFFSET, 8'h80);
		for (int i = 0; i < SRPIE_NSRC; i++) begin
			wr(SRPIE_XIE_OFFSET, 8'(1 << i));
			settle(2);
			chk("single source", 16'(1 << i), irq_req);
			chk("any request", 1, irq_any);
		end
		for (int i = 0; i < 2; i++) begin
			flags <= srpie_flags_t'({(i == 0), (i == 1), 5'b00000});
			settle(2);
			chk("comparator edge", 16'h20, irq_req);
		end
		flags <= '1;
		wr(SRPIE_XIE_OFFSET, 8'h00);
		settle(2);
		chk("all masked", 0, {irq_any, irq_req});
		wr(SRPIE_XIE_OFFSET, 8'h01);
		flags <= '0;
		wr(SRPIE_PWR_OFFSET, 8'hFD);
		settle(2);
		chk("idle clocks", 1, {cpu_clk_en, osc_run});
		chk("idle mode", 1, cpu_mode_idle);
		rd(SRPIE_PWR_OFFSET, "idle bit reads zero", 8'hFC);
		flags.two_wire_flag <= 1'b1;
		settle(3);
		chk("idle woken", 2, {cpu_clk_en, cpu_mode_idle});
		flags <= '0;
		wr(SRPIE_PWR_OFFSET, 8'hFE);
		settle(2);
		chk("stop mode", 1, {osc_run, cpu_mode_stop});
		rd(SRPIE_PWR_OFFSET, "stop bit reads zero", 8'hFC);
		flags.two_wire_flag <= 1'b1;
		settle(3);
		chk("stop holds", 0, osc_run);
		rst(1'b0);
		rd(SRPIE_PWR_OFFSET, "pwr after reset", 8'h00);
		rd(SRPIE_CTL_OFFSET, "global after reset", 8'h00);
		ticks = 0;
		for (int i = 0; i < 120; i++) begin
			settle(1);
			ticks += int'(wdt_tick);
		end
		chk("watchdog ticks", 16'd10, 16'(ticks));
		tally_and_finish();
	end
endmodule : srpie_top_bench
`default_nettype wire
